/* design/fsr_status_regs.sv */
// Summary of operation
// - opcode 05h selects register one; its bits stream out starting next clock.
// - after bit 0 the stream restarts at bit 7 while selected and clocked.
// - every repeated byte carries live register contents, busy changes included.
// - chip select high ends the read and floats the serial output.
// - chip select may rise at any bit position without error.
// - status reads are accepted even while program or erase runs.
// - opcode 35h streams register two the same repeating way.
// - register three reads with 15h and writes with 11h.
// - writes change only writable bits; read-only bits keep hardware values.
// - register one bits 7..2 are writable protect, sector, top/bottom, levels.
// - register one bit 1 is the read-only write enable latch, default 0.
// - register one bit 0 is the read-only busy flag.
// - register two bit 7 is read-only erase suspended, default 0.
// - register two bit 2 is read-only program suspended, default 0.
// - register two bit 6 is writable protect complement, default 0.
// - register two bits 5..3 are writable page locks, default unlocked.
// - register two bit 1 is writable quad enable, default 1.
// - register two bit 0 is writable status protect high bit.
// - register three bits 6:5 set output drive, default 11.
// - drive field 11 lets the device pick strength from supply.
// - write enable latch reads 0 after reset and clears after operations.
`timescale 1ns/1ps
module fsr_status_regs
	import fsr_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// serial pins
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic SI,
	input wire logic WP_N,
	output logic SO,
	output logic SO_OE,
	// core status
	input wire logic PE_BUSY,
	input wire logic ERASE_SUSP,
	input wire logic PROG_SUSP,
	input wire logic OP_END,
	input wire logic VCC_LOW,
	// configuration out
	output logic [2:0] BLOCK_PROTECT,
	output logic TOP_BOTTOM,
	output logic SECTOR_SIZE,
	output logic PROT_COMPLEMENT,
	output logic [2:0] PAGE_LOCK,
	output logic QUAD_IO_EN,
	output logic [1:0] DRIVE_LEVEL,
	output logic WRITE_ENABLED,
	output logic SR_WRITE_BUSY
);
	import fsr_pkg::*;

	// ----------------------------------------
	// pin sampling and edges
	// ----------------------------------------
	logic [3:0] pin_s;
	logic cs_n_s;
	logic sclk_s;
	logic si_s;
	logic wp_n_s;
	logic sclk_p_q;
	logic cs_p_q;
	logic rise;
	logic fall;
	logic cs_end;

	fsr_sync #(.W(4)) u_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.din({WP_N, SI, SCLK, ~CS_N}),
		.dout(pin_s)
	);

	// select is carried inverted so the synchroniser's reset reads as deselected
	assign cs_n_s = ~pin_s[0];
	assign sclk_s = pin_s[1];
	assign si_s = pin_s[2];
	assign wp_n_s = pin_s[3];
	assign rise = sclk_s & ~sclk_p_q & ~cs_n_s;
	assign fall = ~sclk_s & sclk_p_q & ~cs_n_s;
	assign cs_end = cs_n_s & ~cs_p_q;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sclk_p_q <= 1'b0;
			cs_p_q <= 1'b1;
		end else begin
			sclk_p_q <= sclk_s;
			cs_p_q <= cs_n_s;
		end
	end

	// ----------------------------------------
	// live register images
	// ----------------------------------------
	logic [7:0] sr1_q;
	logic [7:0] sr2_q;
	logic [7:0] sr3_q;
	logic wel_q;
	logic wbusy_q;
	logic busy;
	logic locked;
	logic [7:0] sr1_live;
	logic [7:0] sr2_live;
	logic [7:0] sr3_live;
	logic [1:0] sel_q;
	logic [7:0] live;

	assign busy = wbusy_q | PE_BUSY;
	// 11 on both protect bits treated as locked too
	assign locked = sr2_q[SR2_SPH] | (sr1_q[SR1_SPL] & ~wp_n_s);

	always_comb begin
		sr1_live = sr1_q & SR1_WMASK;
		sr1_live[SR1_WRLATCH] = wel_q;
		sr1_live[SR1_BUSY] = busy;
		sr2_live = sr2_q & SR2_WMASK;
		sr2_live[SR2_ESUS] = ERASE_SUSP;
		sr2_live[SR2_PSUS] = PROG_SUSP;
		sr3_live = sr3_q & SR3_WMASK;
		case (sel_q)
			SEL_SR1: live = sr1_live;
			SEL_SR2: live = sr2_live;
			default: live = sr3_live;
		endcase
	end

	// ----------------------------------------
	// serial command engine
	// ----------------------------------------
	fsr_state_e state_q;
	fsr_state_e state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] cmd_q;
	logic [7:0] cmd_d;
	logic [1:0] sel_d;
	logic [2:0] idx_q;
	logic [2:0] idx_d;
	logic [7:0] snap_q;
	logic [7:0] snap_d;
	logic so_q;
	logic so_d;
	logic oe_q;
	logic oe_d;
	logic over_q;
	logic over_d;
	logic [7:0] opc;
	logic do_wr;
	logic do_wren;
	logic do_wrdi;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		cmd_d = cmd_q;
		sel_d = sel_q;
		idx_d = idx_q;
		snap_d = snap_q;
		so_d = so_q;
		oe_d = oe_q;
		over_d = over_q;
		opc = {sh_q[6:0], si_s};
		do_wr = 1'b0;
		do_wren = 1'b0;
		do_wrdi = 1'b0;
		if (cs_n_s) begin
			// deselect ends any command at any bit position
			if (cs_end) begin
				do_wr = (state_q == FSR_WDAT) && (cnt_q == BYTE_BITS) && !over_q;
				do_wren = (state_q == FSR_SKIP) && !over_q && (cmd_q == OP_WREN);
				do_wrdi = (state_q == FSR_SKIP) && !over_q && (cmd_q == OP_WRDI);
			end
			state_d = FSR_OPC;
			cnt_d = '0;
			over_d = 1'b0;
			oe_d = 1'b0;
		end else begin
			case (state_q)
				FSR_OPC: begin
					if (rise) begin
						sh_d = opc;
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == OPC_LAST) begin
							cmd_d = opc;
							cnt_d = '0;
							idx_d = BIT_MSB;
							state_d = FSR_SKIP;
							// reads accepted regardless of busy
							case (opc)
								OP_RD_SR1: begin
									sel_d = SEL_SR1;
									state_d = FSR_RD;
								end
								OP_RD_SR2: begin
									sel_d = SEL_SR2;
									state_d = FSR_RD;
								end
								OP_RD_SR3: begin
									sel_d = SEL_SR3;
									state_d = FSR_RD;
								end
								OP_WR_SR1: begin
									sel_d = SEL_SR1;
									state_d = FSR_WDAT;
								end
								OP_WR_SR2: begin
									sel_d = SEL_SR2;
									state_d = FSR_WDAT;
								end
								OP_WR_SR3: begin
									sel_d = SEL_SR3;
									state_d = FSR_WDAT;
								end
								default: begin
									state_d = FSR_SKIP;
								end
							endcase
						end
					end
				end
				FSR_RD: begin
					if (fall) begin
						oe_d = 1'b1;
						// byte start takes a fresh snapshot so polling sees updates
						if (idx_q == BIT_MSB) begin
							snap_d = live;
							so_d = live[BIT_MSB];
						end else begin
							so_d = snap_q[idx_q];
						end
						idx_d = idx_q - 3'h1;
					end
				end
				FSR_WDAT: begin
					if (rise) begin
						sh_d = opc;
						if (cnt_q == BYTE_BITS) begin
							over_d = 1'b1;
						end else begin
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				FSR_SKIP: begin
					if (rise) begin
						over_d = 1'b1;
					end
				end
				default: begin
					state_d = FSR_OPC;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_q <= FSR_OPC;
			cnt_q <= '0;
			sh_q <= '0;
			cmd_q <= '0;
			sel_q <= SEL_SR1;
			idx_q <= BIT_MSB;
			snap_q <= '0;
			so_q <= 1'b0;
			oe_q <= 1'b0;
			over_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			cmd_q <= cmd_d;
			sel_q <= sel_d;
			idx_q <= idx_d;
			snap_q <= snap_d;
			so_q <= so_d;
			oe_q <= oe_d;
			over_q <= over_d;
		end
	end

	// ----------------------------------------
	// register update and write cycle
	// ----------------------------------------
	logic [7:0] sr1_d;
	logic [7:0] sr2_d;
	logic [7:0] sr3_d;
	logic wel_d;
	logic wbusy_d;
	logic [11:0] wcnt_q;
	logic [11:0] wcnt_d;

	always_comb begin
		sr1_d = sr1_q;
		sr2_d = sr2_q;
		sr3_d = sr3_q;
		wel_d = wel_q;
		wbusy_d = wbusy_q;
		wcnt_d = wcnt_q;
		if (wbusy_q) begin
			wcnt_d = wcnt_q - WCNT_ONE;
			if (wcnt_q == WCNT_ONE) begin
				wbusy_d = 1'b0;
				wel_d = 1'b0;
			end
		end
		if (OP_END || do_wrdi) begin
			wel_d = 1'b0;
		end
		if (state_q == FSR_WDAT && cs_end) begin
			// full opcode seen: an ending drops the latch unless the write is accepted, which holds it until the write cycle ends
			wel_d = 1'b0;
			if (do_wr && wel_q && !locked && !busy) begin
				wel_d = 1'b1;
				wbusy_d = 1'b1;
				wcnt_d = WRSR_CNT;
				case (sel_q)
					SEL_SR1: sr1_d = fsr_merge(sr1_q, sh_q, SR1_WMASK);
					SEL_SR2: sr2_d = fsr_merge(sr2_q, sh_q, SR2_WMASK);
					default: sr3_d = fsr_merge(sr3_q, sh_q, SR3_WMASK);
				endcase
			end
		end
		// a set in the same cycle as a clear wins
		if (do_wren) begin
			wel_d = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sr1_q <= SR1_RST;
			sr2_q <= SR2_RST;
			sr3_q <= SR3_RST;
			wel_q <= 1'b0;
			wbusy_q <= 1'b0;
			wcnt_q <= '0;
		end else begin
			sr1_q <= sr1_d;
			sr2_q <= sr2_d;
			sr3_q <= sr3_d;
			wel_q <= wel_d;
			wbusy_q <= wbusy_d;
			wcnt_q <= wcnt_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	fsr_drive_sel u_drv (
		.clk(CORE_CLK),
		.rst(RST),
		.field(sr3_q[SR3_DRIVE_HI:SR3_DRIVE_LO]),
		.vcc_low(VCC_LOW),
		.level(DRIVE_LEVEL)
	);

	assign SO = so_q;
	assign SO_OE = oe_q;
	assign BLOCK_PROTECT = sr1_q[4:2];
	assign TOP_BOTTOM = sr1_q[5];
	assign SECTOR_SIZE = sr1_q[6];
	assign PROT_COMPLEMENT = sr2_q[6];
	assign PAGE_LOCK = sr2_q[5:3];
	assign QUAD_IO_EN = sr2_q[SR2_QUAD];
	assign WRITE_ENABLED = wel_q;
	assign SR_WRITE_BUSY = wbusy_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence s_opc_done;
		state_q == FSR_OPC && rise && cnt_q == OPC_LAST;
	endsequence

	sequence s_rd_entry;
		state_q == FSR_RD && idx_q == BIT_MSB;
	endsequence

	a_rd1_start: assert property (s_opc_done ##0 opc == OP_RD_SR1 |=> s_rd_entry ##0 sel_q == SEL_SR1)
		else $error("read one not started");
	a_rd2_start: assert property (s_opc_done ##0 opc == OP_RD_SR2 |=> s_rd_entry ##0 sel_q == SEL_SR2)
		else $error("read two not started");
	a_rd_busy: assert property (s_opc_done ##0 opc == OP_RD_SR3 && PE_BUSY |=> s_rd_entry)
		else $error("read refused while busy");
	a_wrap_msb: assert property (state_q == FSR_RD && fall && idx_q == 3'h0 |=> idx_q == BIT_MSB)
		else $error("stream did not wrap to bit 7");
	a_snap_live: assert property (s_rd_entry ##0 fall |=> snap_q == $past(live) && so_q == $past(live[7]))
		else $error("byte start not taken from live value");
	a_cs_float: assert property (cs_n_s |=> !SO_OE ##1 !SO_OE)
		else $error("output driven while deselected");
	a_so_edge: assert property (!cs_n_s && !fall |=> $stable(so_q))
		else $error("output changed off a falling edge");
	a_ro_bits: assert property (sr1_live[SR1_WRLATCH] == wel_q && sr2_live[SR2_ESUS] == ERASE_SUSP)
		else $error("read-only bit not hardware value");
	a_res_zero: assert property ((sr3_q & ~SR3_WMASK) == 8'h00 && $past(sr3_live[7]) == 1'b0)
		else $error("reserved bit set");
	a_wel_clear: assert property ($fell(wbusy_q) |-> !wel_q ##1 !wel_q || $past(do_wren))
		else $error("write latch not cleared after write");
endmodule

/* design/fsr_pkg.sv */
package fsr_pkg;

	// ----------------------------------------
	// command opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_RD_SR1 = 8'h05;
	localparam logic [7:0] OP_RD_SR2 = 8'h35;
	localparam logic [7:0] OP_RD_SR3 = 8'h15;
	localparam logic [7:0] OP_WR_SR1 = 8'h01;
	localparam logic [7:0] OP_WR_SR2 = 8'h31;
	localparam logic [7:0] OP_WR_SR3 = 8'h11;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SR1_SPL = 7;
	localparam int SR1_WRLATCH = 1;
	localparam int SR1_BUSY = 0;
	localparam int SR2_ESUS = 7;
	localparam int SR2_PSUS = 2;
	localparam int SR2_QUAD = 1;
	localparam int SR2_SPH = 0;
	localparam int SR3_DRIVE_LO = 5;
	localparam int SR3_DRIVE_HI = 6;

	// ----------------------------------------
	// writable masks and reset values
	// ----------------------------------------
	localparam logic [7:0] SR1_WMASK = 8'hfc;
	localparam logic [7:0] SR2_WMASK = 8'h7b;
	localparam logic [7:0] SR3_WMASK = 8'h60;
	localparam logic [7:0] SR1_RST = 8'h00;
	localparam logic [7:0] SR2_RST = 8'h02;
	localparam logic [7:0] SR3_RST = 8'h60;

	// ----------------------------------------
	// drive encodings
	// ----------------------------------------
	localparam logic [1:0] DRIVE_AUTO = 2'b11;
	localparam logic [1:0] DRIVE_HALF = 2'b10;
	localparam logic [1:0] DRIVE_3Q = 2'b01;
	localparam logic [1:0] DRIVE_FULL = 2'b00;

	// ----------------------------------------
	// serial framing and timing
	// ----------------------------------------
	localparam logic [2:0] BIT_MSB = 3'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] OPC_LAST = 4'h7;
	localparam logic [1:0] SEL_SR1 = 2'h0;
	localparam logic [1:0] SEL_SR2 = 2'h1;
	localparam logic [1:0] SEL_SR3 = 2'h2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_WRSR_NS = 5000;
	localparam int WRSR_CYC = (T_WRSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] WRSR_CNT = 12'(WRSR_CYC);
	localparam logic [11:0] WCNT_ONE = 12'h001;

	typedef enum logic [3:0] {
		FSR_OPC = 4'b0001,
		FSR_RD = 4'b0010,
		FSR_WDAT = 4'b0100,
		FSR_SKIP = 4'b1000
	} fsr_state_e;

	function automatic logic [7:0] fsr_merge(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask);
		fsr_merge = (old_v & ~mask) | (new_v & mask);
	endfunction

endpackage

/* design/fsr_sync.sv */
`timescale 1ns/1ps
module fsr_sync #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins in, synchronised out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s1_d;
	logic [W-1:0] s2_d;

	always_comb begin
		s1_d = din;
		s2_d = s1_q;
	end

	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			dout <= '0;
		end else begin
			s1_q <= s1_d;
			dout <= s2_d;
		end
	end
endmodule

/* design/fsr_drive_sel.sv */
`timescale 1ns/1ps
module fsr_drive_sel
	import fsr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// field and supply sense
	input wire logic [1:0] field,
	input wire logic vcc_low,
	// applied strength
	output logic [1:0] level
);
	logic [1:0] level_d;

	always_comb begin
		level_d = field;
		// auto picks by supply: a weak supply needs full drive
		if (field == DRIVE_AUTO) begin
			level_d = vcc_low ? DRIVE_FULL : DRIVE_3Q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= DRIVE_FULL;
		end else begin
			level <= level_d;
		end
	end
endmodule

/* sim/fsr_host_model.sv */
`timescale 1ns/1ps
module fsr_host_model (
	// clock
	input wire logic clk,
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic [7:0] got_byte;
	event got_ev;

	// ----------------------------------------
	// link clock of 130 ns, as 6 + 7 core cycles
	// ----------------------------------------
	// sclk idles low between frames, so it stands still outside them
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
		got_byte = 8'h00;
	end

	task automatic bit_x(input logic b, output logic s);
		si = b;
		repeat (6) @(negedge clk);
		s = so_oe ? so : 1'bx;
		sclk = 1'b1;
		repeat (7) @(negedge clk);
		sclk = 1'b0;
	endtask

	// ----------------------------------------
	// one frame: opcode, nd data bits, nr read bits
	// ----------------------------------------
	task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nd, input int nr);
		logic s;
		logic [7:0] acc;
		acc = 8'h00;
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) bit_x(op[i], s);
		for (int i = 0; i < nd; i++) bit_x(dat[7 - (i % 8)], s);
		for (int i = 0; i < nr; i++) begin
			// data in is meaningless here, so it keeps changing
			bit_x(~si, s);
			acc = {acc[6:0], s};
			if (i % 8 == 7) begin
				got_byte = acc;
				->got_ev;
			end
		end
		repeat (2) @(negedge clk);
		cs_n = 1'b1;
		si = ~si;
		repeat (8) @(negedge clk);
	endtask
endmodule

/* sim/tb_fsr_status_regs.sv */
`timescale 1ns/1ps
module tb_fsr_status_regs;
	import fsr_pkg::*;
	logic clk, rst, wp_n, pe_busy, esus, psus, op_end, vcc_low;
	logic cs_n, sclk, si, so, so_oe, tbs, sector, pcomp, quad_en, write_enable_latch, wbusy;
	logic [2:0] bp;
	logic [2:0] lock;
	logic [1:0] drive;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h3b40;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;

	// ----------------------------------------
	// clock, design and far side
	// ----------------------------------------
	always #5 clk = ~clk;

	fsr_status_regs dut (.CORE_CLK(clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk), .SI(si),
		.WP_N(wp_n), .SO(so), .SO_OE(so_oe), .PE_BUSY(pe_busy), .ERASE_SUSP(esus),
		.PROG_SUSP(psus), .OP_END(op_end), .VCC_LOW(vcc_low), .BLOCK_PROTECT(bp),
		.TOP_BOTTOM(tbs), .SECTOR_SIZE(sector), .PROT_COMPLEMENT(pcomp), .PAGE_LOCK(lock),
		.QUAD_IO_EN(quad_en), .DRIVE_LEVEL(drive), .WRITE_ENABLED(write_enable_latch), .SR_WRITE_BUSY(wbusy));

	fsr_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(host.got_ev) begin
		if (exp_q.size() == 0) begin
			num_errors++;
			$display("ERROR t=%0t unexpected byte", $time);
		end else begin
			chk8(host.got_byte, exp_q.pop_front(), "status byte");
		end
	end

	// bound sized for about 9k cycles of traffic
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			give_verdict();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic rd(input logic [7:0] op, input logic [7:0] e);
		exp_q.push_back(e);
		host.frame(op, 8'h00, 0, 8);
	endtask

	task automatic wr(input logic [7:0] op, input logic [7:0] d, input int nd, input bit wt);
		host.frame(OP_WREN, 8'h00, 0, 0);
		host.frame(op, d, nd, 0);
		for (int i = 0; wt && i < 1000 && wbusy !== 1'b0; i++) @(negedge clk);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] s1;
		clk = 1'b0;
		rst = 1'b1;
		wp_n = 1'b1;
		pe_busy = 1'b0;
		esus = 1'b0;
		psus = 1'b0;
		op_end = 1'b0;
		vcc_low = 1'b0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		rd(OP_RD_SR1, 8'h00);
		rd(OP_RD_SR2, 8'h02);
		rd(OP_RD_SR3, 8'h60);
		chk8({6'h0, drive}, 8'h01, "auto drive");
		// poll across a busy change without a new command
		pe_busy = 1'b1;
		esus = 1'b1;
		psus = 1'b1;
		exp_q.push_back(8'h01);
		exp_q.push_back(8'h00);
		fork
			host.frame(OP_RD_SR1, 8'h00, 0, 16);
			begin
				repeat (150) @(negedge clk);
				pe_busy = 1'b0;
				chk8({7'h0, so_oe}, 8'h01, "so enable");
			end
		join
		rd(OP_RD_SR2, 8'h86);
		esus = 1'b0;
		psus = 1'b0;
		exp_q.push_back(8'h02);
		host.frame(OP_RD_SR2, 8'h00, 0, 11);
		chk8({7'h0, so_oe}, 8'h00, "so float");
		rd(OP_RD_SR2, 8'h02);
		seed = xs(seed);
		d = seed[7:0] | 8'h03;
		s1 = d & 8'hfc;
		wr(OP_WR_SR1, d, 8, 0);
		rd(OP_RD_SR1, s1 | 8'h03);
		chk8({7'h0, wbusy}, 8'h01, "write busy");
		for (int i = 0; i < 1000 && wbusy !== 1'b0; i++) @(negedge clk);
		rd(OP_RD_SR1, s1);
		chk8({5'h0, bp}, {5'h0, d[4:2]}, "levels");
		chk8({6'h0, sector, tbs}, {6'h0, d[6:5]}, "sector tb");
		// bit 0 kept clear so the protect pair never locks
		seed = xs(seed);
		d = (seed[7:0] & 8'hfe) | 8'h84;
		wr(OP_WR_SR2, d, 8, 1);
		rd(OP_RD_SR2, d & 8'h7a);
		chk8({1'h0, pcomp, lock, 1'b0, quad_en, 1'b0}, d & 8'h7a, "reg2 outs");
		for (int c = 0; c < 4; c++) begin
			wr(OP_WR_SR3, {1'b1, c[1:0], 5'h1f}, 8, 1);
			rd(OP_RD_SR3, {1'b0, c[1:0], 5'h00});
			chk8({6'h0, drive}, (c == 3) ? 8'h01 : 8'(c), "drive");
		end
		vcc_low = 1'b1;
		repeat (4) @(negedge clk);
		chk8({6'h0, drive}, 8'h00, "auto low");
		host.frame(OP_WR_SR3, 8'h00, 8, 0);
		wr(OP_WR_SR3, 8'h00, 9, 1);
		chk8({7'h0, write_enable_latch}, 8'h00, "latch after drop");
		rd(OP_RD_SR3, 8'h60);
		host.frame(OP_WREN, 8'h00, 0, 0);
		rd(OP_RD_SR1, s1 | 8'h02);
		op_end = 1'b1;
		@(negedge clk);
		op_end = 1'b0;
		repeat (2) @(negedge clk);
		chk8({7'h0, write_enable_latch}, 8'h00, "latch op end");
		host.frame(OP_WREN, 8'h00, 0, 0);
		host.frame(OP_WRDI, 8'h00, 0, 0);
		chk8({7'h0, write_enable_latch}, 8'h00, "latch disable");
		repeat (4) @(negedge clk);
		if (exp_q.size() != 0) begin
			num_errors++;
			$display("ERROR t=%0t bytes missing", $time);
		end
		give_verdict();
	end
endmodule
